// ---- common/wpcm_params.svh ----
// Register indices, field positions, reset values and CRC constants of the
// wake-up pattern matcher. Assumes byte address = 4 * register index.
`ifndef WPCM_PARAMS_SVH
`define WPCM_PARAMS_SVH

// Register indices (byte address is four times the index)
`define WPCM_IDX_P2_CRC_LO 10'h050
`define WPCM_IDX_P2_CRC_HI 10'h052
`define WPCM_IDX_P2_BSEL0 10'h054
`define WPCM_IDX_P2_BSEL1 10'h056
`define WPCM_IDX_P2_BSEL2 10'h058
`define WPCM_IDX_P2_BSEL3 10'h05A
`define WPCM_IDX_P3_CRC_LO 10'h060
`define WPCM_IDX_P3_CRC_HI 10'h062
`define WPCM_IDX_P3_BSEL0 10'h064
`define WPCM_IDX_P3_BSEL1 10'h066
`define WPCM_IDX_P3_BSEL2 10'h068
`define WPCM_IDX_P3_BSEL3 10'h06A
`define WPCM_IDX_CTRL 10'h06C
`define WPCM_IDX_STAT 10'h06E

// Slot numbers inside one pattern's register group
`define WPCM_SLOT_CRC_LO 3'h0
`define WPCM_SLOT_CRC_HI 3'h1
`define WPCM_SLOT_BSEL0 3'h2
`define WPCM_SLOT_BSEL1 3'h3
`define WPCM_SLOT_BSEL2 3'h4
`define WPCM_SLOT_BSEL3 3'h5

// Field positions and reset values
`define WPCM_CTRL_EN_LSB 0
`define WPCM_STAT_MATCH_LSB 0
`define WPCM_REG_RESET 16'h0000

// Frame window and CRC-32 (reflected form)
`define WPCM_WINDOW_BYTES 7'h40
`define WPCM_CRC_INIT 32'hFFFFFFFF
`define WPCM_CRC_POLY 32'hEDB88320

// Bus responses
`define WPCM_RESP_OKAY 2'h0
`define WPCM_RESP_SLVERR 2'h2

`endif

// ---- common/wpcm_pkg.sv ----
// Types shared by the wake-up pattern matcher modules.
// Assumes the constants header is included by each user.
package wpcm_pkg;
	typedef enum logic [2:0] {
		FS_IDLE = 3'b001,
		FS_COLLECT = 3'b010,
		FS_CHECK = 3'b100
	} wpcm_frame_state_t;

	typedef enum logic [1:0] {
		RK_NONE = 2'h0,
		RK_CFG = 2'h1,
		RK_CTRL = 2'h2,
		RK_STAT = 2'h3
	} wpcm_reg_kind_t;

	typedef struct packed {
		wpcm_reg_kind_t kind;
		logic pat;
		logic [2:0] slot;
	} wpcm_dec_t;
endpackage : wpcm_pkg

// ---- common/wpcm_frame_if.sv ----
// Received byte stream annotated with its position in the frame.
// Assumes one producer (byte tracker) and any number of pattern engines.
`timescale 1ns/10ps
interface wpcm_frame_if;
	logic valid;
	logic [7:0] data;
	logic [6:0] pos;
	logic last;
	modport src (output valid, output data, output pos, output last);
	modport dst (input valid, input data, input pos, input last);
endinterface : wpcm_frame_if

// ---- hw/wpcm_byte_track.sv ----
// Numbers the bytes of each received frame from zero.
// Assumes the MAC receive path runs on aclk and marks each frame's last byte.
`timescale 1ns/10ps
`include "wpcm_params.svh"
module wpcm_byte_track
	import wpcm_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic rx_valid, // Byte present
	input wire logic [7:0] rx_data, // Byte value
	input wire logic rx_last, // Byte ends the frame
	wpcm_frame_if.src frame // Annotated stream
);
	logic [6:0] pos;

	// Saturates at the window size so long frames never wrap into the mask
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos <= 7'h00;
		end else if (rx_valid) begin
			if (rx_last) begin
				pos <= 7'h00;
			end else if (pos != `WPCM_WINDOW_BYTES) begin
				pos <= pos + 7'h01;
			end
		end
	end

	assign frame.valid = rx_valid;
	assign frame.data = rx_data;
	assign frame.last = rx_last;
	assign frame.pos = pos;
endmodule : wpcm_byte_track

// ---- hw/wpcm_crc_match.sv ----
// One pattern engine: CRC over selected bytes, compare at frame end.
// Assumes mask and expected value are stable while a frame is received.
`timescale 1ns/10ps
`include "wpcm_params.svh"
module wpcm_crc_match
	import wpcm_pkg::*;
(
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	wpcm_frame_if.dst frame, // Annotated stream
	input wire logic enable, // Pattern enabled
	input wire logic [63:0] mask, // Byte select, bit n is byte n+1
	input wire logic [31:0] expected, // Expected CRC
	output logic byte_sel, // Current byte is selected
	output logic match // One-cycle match pulse
);
	wpcm_frame_state_t state;
	logic [31:0] crc;
	logic [31:0] base;
	logic hit;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `WPCM_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	// [R3] [R4] [R5] [R6] position to mask bit
	assign byte_sel = (frame.pos < `WPCM_WINDOW_BYTES) && mask[frame.pos[5:0]];
	assign base = (frame.pos == 7'h00) ? `WPCM_CRC_INIT : crc;
	// An empty mask with a zero expected CRC would match every frame, so it never counts
	assign hit = ((~crc) == expected) && enable && (|mask);

	// [R1] masked CRC update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc <= `WPCM_CRC_INIT;
		end else if (frame.valid) begin
			crc <= byte_sel ? crc_byte(base, frame.data) : base;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= FS_IDLE;
		end else begin
			case (state)
				FS_IDLE, FS_COLLECT: begin
					if (frame.valid) begin
						state <= frame.last ? FS_CHECK : FS_COLLECT;
					end
				end
				// A one-byte frame straight after a check must be checked as well
				FS_CHECK: begin
					if (frame.valid) begin
						state <= frame.last ? FS_CHECK : FS_COLLECT;
					end else begin
						state <= FS_IDLE;
					end
				end
				default: begin
					state <= FS_IDLE;
				end
			endcase
		end
	end

	// [R7] compare at frame end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match <= 1'b0;
		end else begin
			match <= (state == FS_CHECK) && hit;
		end
	end

	sequence s_check_hit;
		(state == FS_CHECK) && hit;
	endsequence

	match_after_check_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		s_check_hit |=> match)
		else $error("match missing after a hitting check");
	match_cause_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		match |-> $past(state == FS_CHECK) && $past(hit))
		else $error("match without a hitting check");
	skip_unselected_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
		frame.valid && !byte_sel && frame.pos != 7'h00 |=> crc == $past(crc))
		else $error("unselected byte changed the CRC");
endmodule : wpcm_crc_match

// ---- hw/wpcm_top.sv ----
// Wake-up frame pattern matcher for patterns 2 and 3 with AXI4-Lite registers.
// Assumes rx_* come from the MAC receive path on aclk, one byte per valid.
//
// Summary of operation
// [R1] CRC-32 per pattern is taken only over frame bytes whose mask bit is set.
// [R2] Expected CRC: lower register holds bits 15..0, next register bits 31..16.
// [R3] Mask word 0: bit 0 selects frame byte 1, bit 15 byte 16.
// [R4] Mask word 1: bit 0 selects frame byte 17, bit 15 byte 32.
// [R5] Mask word 2: bit 0 selects frame byte 33, bit 15 byte 48.
// [R6] Mask word 3: bit 0 selects byte 49, bit 15 byte 64; later bytes ignored.
// [R7] A pattern matches when masked-byte CRC equals its stored expected CRC; the code never matches a pattern whose mask is empty.
`timescale 1ns/10ps
`include "wpcm_params.svh"
module wpcm_top
	import wpcm_pkg::*;
#(
	parameter int NPAT = 2, // Patterns held
	parameter int ADDR_W = 12 // Byte address width
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic rx_valid, // Received byte present
	input wire logic [7:0] rx_data, // Received byte
	input wire logic rx_last, // Last byte of the frame
	output logic [NPAT-1:0] match_pulse // One-cycle pattern match
);
	logic [15:0] cfg [NPAT][6];
	logic [NPAT-1:0] enable;
	logic [NPAT-1:0] stat;
	logic [63:0] mask [NPAT];
	logic [31:0] expected [NPAT];
	logic [NPAT-1:0] byte_sel;

	logic aw_got;
	logic w_got;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;
	wpcm_dec_t wdec;
	wpcm_dec_t rdec;
	logic [15:0] next_rdata;

	// Index decode shared by the write and read paths
	function automatic wpcm_dec_t decode(input logic [ADDR_W-1:0] addr);
		wpcm_dec_t d;
		d.kind = RK_NONE;
		d.pat = 1'b0;
		d.slot = 3'h0;
		case (10'(addr >> 2))
			`WPCM_IDX_P2_CRC_LO: begin d.kind = RK_CFG; d.slot = `WPCM_SLOT_CRC_LO; end
			`WPCM_IDX_P2_CRC_HI: begin d.kind = RK_CFG; d.slot = `WPCM_SLOT_CRC_HI; end
			`WPCM_IDX_P2_BSEL0: begin d.kind = RK_CFG; d.slot = `WPCM_SLOT_BSEL0; end
			`WPCM_IDX_P2_BSEL1: begin d.kind = RK_CFG; d.slot = `WPCM_SLOT_BSEL1; end
			`WPCM_IDX_P2_BSEL2: begin d.kind = RK_CFG; d.slot = `WPCM_SLOT_BSEL2; end
			`WPCM_IDX_P2_BSEL3: begin d.kind = RK_CFG; d.slot = `WPCM_SLOT_BSEL3; end
			`WPCM_IDX_P3_CRC_LO: begin
				d.kind = RK_CFG;
				d.pat = 1'b1;
				d.slot = `WPCM_SLOT_CRC_LO;
			end
			`WPCM_IDX_P3_CRC_HI: begin
				d.kind = RK_CFG;
				d.pat = 1'b1;
				d.slot = `WPCM_SLOT_CRC_HI;
			end
			`WPCM_IDX_P3_BSEL0: begin
				d.kind = RK_CFG;
				d.pat = 1'b1;
				d.slot = `WPCM_SLOT_BSEL0;
			end
			`WPCM_IDX_P3_BSEL1: begin
				d.kind = RK_CFG;
				d.pat = 1'b1;
				d.slot = `WPCM_SLOT_BSEL1;
			end
			`WPCM_IDX_P3_BSEL2: begin
				d.kind = RK_CFG;
				d.pat = 1'b1;
				d.slot = `WPCM_SLOT_BSEL2;
			end
			`WPCM_IDX_P3_BSEL3: begin
				d.kind = RK_CFG;
				d.pat = 1'b1;
				d.slot = `WPCM_SLOT_BSEL3;
			end
			`WPCM_IDX_CTRL: d.kind = RK_CTRL;
			`WPCM_IDX_STAT: d.kind = RK_STAT;
			default: d.kind = RK_NONE;
		endcase
		return d;
	endfunction : decode

	// Write path: address and data may arrive in either order
	assign s_axi_awready = !aw_got && !s_axi_bvalid;
	assign s_axi_wready = !w_got && !s_axi_bvalid;
	assign do_write = aw_got && w_got && !s_axi_bvalid;
	assign wdec = decode(aw_addr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_got <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_got <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WPCM_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wdec.kind == RK_NONE) ? `WPCM_RESP_SLVERR : `WPCM_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// [R2] [R3] [R4] [R5] [R6] pattern register storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int p = 0; p < NPAT; p++) begin
				for (int s = 0; s < 6; s++) begin
					cfg[p][s] <= `WPCM_REG_RESET;
				end
			end
		end else if (do_write && wdec.kind == RK_CFG) begin
			for (int p = 0; p < NPAT; p++) begin
				for (int s = 0; s < 6; s++) begin
					if (wdec.pat == 1'(p) && wdec.slot == 3'(s)) begin
						if (w_strb[0]) begin
							cfg[p][s][7:0] <= w_data[7:0];
						end
						if (w_strb[1]) begin
							cfg[p][s][15:8] <= w_data[15:8];
						end
					end
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= '0;
		end else if (do_write && wdec.kind == RK_CTRL && w_strb[0]) begin
			enable <= w_data[`WPCM_CTRL_EN_LSB +: NPAT];
		end
	end

	// Sticky match flags, write one to clear; a new match wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat <= '0;
		end else if (do_write && wdec.kind == RK_STAT && w_strb[0]) begin
			stat <= (stat & ~w_data[`WPCM_STAT_MATCH_LSB +: NPAT]) | match_pulse;
		end else begin
			stat <= stat | match_pulse;
		end
	end

	// Read path: one answer outstanding, data registered
	assign s_axi_arready = !s_axi_rvalid;
	assign rdec = decode(s_axi_araddr);

	always_comb begin
		next_rdata = 16'h0000;
		case (rdec.kind)
			RK_CFG: next_rdata = cfg[rdec.pat][rdec.slot];
			RK_CTRL: next_rdata = 16'(enable);
			RK_STAT: next_rdata = 16'(stat);
			default: next_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `WPCM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, next_rdata};
			s_axi_rresp <= (rdec.kind == RK_NONE) ? `WPCM_RESP_SLVERR : `WPCM_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Frame side
	wpcm_frame_if frame ();

	wpcm_byte_track u_track (
		.aclk(aclk),
		.aresetn(aresetn),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_last(rx_last),
		.frame(frame)
	);

	genvar gp;
	generate
		for (gp = 0; gp < NPAT; gp++) begin : g_pat
			// [R2] low register is bits 15..0
			assign expected[gp] = {cfg[gp][`WPCM_SLOT_CRC_HI], cfg[gp][`WPCM_SLOT_CRC_LO]};
			// [R3] [R4] [R5] [R6] word 0 lowest bytes
			assign mask[gp] = {cfg[gp][`WPCM_SLOT_BSEL3], cfg[gp][`WPCM_SLOT_BSEL2],
				cfg[gp][`WPCM_SLOT_BSEL1], cfg[gp][`WPCM_SLOT_BSEL0]};

			wpcm_crc_match u_match (
				.aclk(aclk),
				.aresetn(aresetn),
				.frame(frame),
				.enable(enable[gp]),
				.mask(mask[gp]),
				.expected(expected[gp]),
				.byte_sel(byte_sel[gp]),
				.match(match_pulse[gp])
			);
		end
	endgenerate

	crc_high_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		do_write && 10'(aw_addr >> 2) == `WPCM_IDX_P2_CRC_HI && w_strb[1:0] == 2'h3
		|=> expected[0][31:16] == $past(w_data[15:0]))
		else $error("upper CRC half not taken from its register");
	crc_low_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
		do_write && 10'(aw_addr >> 2) == `WPCM_IDX_P3_CRC_LO && w_strb[1:0] == 2'h3
		|=> expected[1][15:0] == $past(w_data[15:0]))
		else $error("lower CRC half not taken from its register");
	word0_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
		frame.valid && frame.pos < 7'h10
		|-> byte_sel[0] == cfg[0][`WPCM_SLOT_BSEL0][frame.pos[3:0]])
		else $error("mask word 0 selects the wrong byte");
	word1_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
		frame.valid && frame.pos >= 7'h10 && frame.pos < 7'h20
		|-> byte_sel[1] == cfg[1][`WPCM_SLOT_BSEL1][frame.pos[3:0]])
		else $error("mask word 1 selects the wrong byte");
	word2_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
		frame.valid && frame.pos >= 7'h20 && frame.pos < 7'h30
		|-> byte_sel[0] == cfg[0][`WPCM_SLOT_BSEL2][frame.pos[3:0]])
		else $error("mask word 2 selects the wrong byte");
	word3_select_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		frame.valid && frame.pos >= 7'h30 && frame.pos < 7'h40
		|-> byte_sel[1] == cfg[1][`WPCM_SLOT_BSEL3][frame.pos[3:0]])
		else $error("mask word 3 selects the wrong byte");
	beyond_window_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
		frame.pos >= `WPCM_WINDOW_BYTES |-> byte_sel == '0)
		else $error("byte past the window was selected");
	// Software may clear the flag once it has been set
	sticky_match_a: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		match_pulse[0] |=> stat[0] ##1 (stat[0] || $past(do_write && wdec.kind == RK_STAT)))
		else $error("match flag lost");
	write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> s_axi_bvalid)
		else $error("write response missing");
endmodule : wpcm_top

// ---- tb/wpcm_rx_model.sv ----
// Stand-in for the MAC receive path: streams one frame, a byte per valid cycle.
// Assumes the bench fills fbuf and calls send_frame only between frames.
`timescale 1ns/10ps
module wpcm_rx_model (
	input wire logic aclk, // System clock
	output logic rx_valid, // Byte present
	output logic [7:0] rx_data, // Byte value
	output logic rx_last // Frame end marker
);
	logic [7:0] fbuf [0:79];

	initial begin
		rx_valid = 1'b0;
		rx_data = 8'hA5;
		rx_last = 1'b0;
	end

	// Idle cycles carry the inverse of the last byte, so stale data never looks valid
	task send_frame(input int len, input int gap);
		int i;
		int g;
		for (i = 0; i < len; i++) begin
			@(posedge aclk);
			rx_valid <= 1'b1;
			rx_data <= fbuf[i];
			rx_last <= (i == len - 1);
			for (g = 0; g < gap && i < len - 1; g++) begin
				@(posedge aclk);
				rx_valid <= 1'b0;
				rx_data <= ~fbuf[i];
				rx_last <= 1'b0;
			end
		end
		@(posedge aclk);
		rx_valid <= 1'b0;
		rx_data <= ~fbuf[len - 1];
		rx_last <= 1'b0;
	endtask : send_frame
endmodule : wpcm_rx_model

// ---- tb/wakeup_pattern_crc_match_test.sv ----
// Self-checking bench: AXI4-Lite register access and masked-CRC frame matching.
// Assumes the rx model is the only source of received bytes.
`timescale 1ns/10ps
`include "wpcm_params.svh"
module wakeup_pattern_crc_match_test;
	import wpcm_pkg::*;
	localparam logic [9:0] RIDX [14] = '{`WPCM_IDX_P2_CRC_LO, `WPCM_IDX_P2_CRC_HI,
		`WPCM_IDX_P2_BSEL0, `WPCM_IDX_P2_BSEL1, `WPCM_IDX_P2_BSEL2, `WPCM_IDX_P2_BSEL3,
		`WPCM_IDX_P3_CRC_LO, `WPCM_IDX_P3_CRC_HI, `WPCM_IDX_P3_BSEL0, `WPCM_IDX_P3_BSEL1,
		`WPCM_IDX_P3_BSEL2, `WPCM_IDX_P3_BSEL3, `WPCM_IDX_CTRL, `WPCM_IDX_STAT};
	localparam int FLIP [12] = '{-1, 64, 1, 0, 15, 16, 31, 32, 47, 48, 63, 69};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_last;
	logic [1:0] bresp, rresp, match_pulse, r;
	logic [31:0] rdata, d;
	logic [7:0] rx_data;
	logic [7:0] fr [0:79];
	logic [63:0] msk [2];
	logic [31:0] ecrc [2];
	int mismatches = 0;
	int checks_done = 0;
	int i, p, c;

	always #2 aclk = ~aclk;

	wpcm_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last), .match_pulse(match_pulse));

	wpcm_rx_model mdl (.aclk(aclk), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_last(rx_last));

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rs = bresp;
		bready <= 1'b0;
		if (n == 40) begin
			mismatches++;
			end_sim();
		end
	endtask : axw

	task axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (n == 40) begin
			mismatches++;
			end_sim();
		end
	endtask : axr

	// Reference CRC-32 over the selected bytes of fr, bit k of m is byte k+1
	function automatic logic [31:0] ref_crc(input logic [63:0] m);
		logic [31:0] cr;
		cr = `WPCM_CRC_INIT;
		for (int k = 0; k < 64; k++) begin
			if (m[k]) begin
				cr ^= {24'h000000, fr[k]};
				for (int j = 0; j < 8; j++)
					cr = cr[0] ? ((cr >> 1) ^ `WPCM_CRC_POLY) : (cr >> 1);
			end
		end
		return ~cr;
	endfunction : ref_crc

	// Pulse must stand exactly one cycle, two edges after the last byte
	task frame_chk(input int gap, input logic [1:0] exp);
		mdl.fbuf = fr;
		mdl.send_frame(70, gap);
		@(posedge aclk);
		#1;
		chk("match pulse", {30'h0, match_pulse}, {30'h0, exp});
		@(posedge aclk);
		#1;
		chk("match pulse end", {30'h0, match_pulse}, 32'h0);
	endtask : frame_chk

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 14; i++) begin
			axr({RIDX[i], 2'b00}, d, r);
			chk("reset value", d, 32'h0);
		end
		for (i = 0; i < 12; i++) begin
			axw({RIDX[i], 2'b00}, {16'hFFFF, 8'h5A, 8'(i)}, r);
			chk("write resp", {30'h0, r}, {30'h0, `WPCM_RESP_OKAY});
			axr({RIDX[i], 2'b00}, d, r);
			chk("readback", d, {16'h0000, 8'h5A, 8'(i)});
		end
		// byte strobes, only the upper byte lands
		wstrb <= 4'h2;
		axw({RIDX[2], 2'b00}, 32'h0000BBCC, r);
		wstrb <= 4'hF;
		axr({RIDX[2], 2'b00}, d, r);
		chk("strobed write", d, 32'h0000BB02);
		axw(12'h170, 32'h0000FFFF, r);
		chk("unmapped write resp", {30'h0, r}, {30'h0, `WPCM_RESP_SLVERR});
		axr(12'h170, d, r);
		chk("unmapped read", d, 32'h0);
		chk("unmapped read resp", {30'h0, r}, {30'h0, `WPCM_RESP_SLVERR});
		$display("test registers done");
		for (i = 0; i < 80; i++) fr[i] = 8'(i * 29 + 7);
		msk[0] = 64'h8001_8001_8001_8001;
		msk[1] = 64'h4000_0001_0FF0_1234;
		for (p = 0; p < 2; p++) begin
			ecrc[p] = ref_crc(msk[p]);
			axw({RIDX[p * 6], 2'b00}, {16'h0000, ecrc[p][15:0]}, r);
			axw({RIDX[p * 6 + 1], 2'b00}, {16'h0000, ecrc[p][31:16]}, r);
			for (i = 0; i < 4; i++)
				axw({RIDX[p * 6 + 2 + i], 2'b00}, {16'h0000, msk[p][i * 16 +: 16]}, r);
		end
		axw({`WPCM_IDX_CTRL, 2'b00}, 32'h3, r);
		for (c = 0; c < 12; c++) begin
			if (FLIP[c] >= 0) fr[FLIP[c]] ^= 8'hFF;
			frame_chk(c % 2, {ref_crc(msk[1]) == ecrc[1], ref_crc(msk[0]) == ecrc[0]});
			if (FLIP[c] >= 0) fr[FLIP[c]] ^= 8'hFF;
		end
		$display("test mask windows done");
		// sticky status, enable, CRC halves order
		axr({`WPCM_IDX_STAT, 2'b00}, d, r);
		chk("status after matches", d, 32'h3);
		axw({`WPCM_IDX_STAT, 2'b00}, 32'h3, r);
		axr({`WPCM_IDX_STAT, 2'b00}, d, r);
		chk("status cleared", d, 32'h0);
		axw({`WPCM_IDX_CTRL, 2'b00}, 32'h1, r);
		frame_chk(0, 2'b01);
		axw({`WPCM_IDX_CTRL, 2'b00}, 32'h3, r);
		axw({RIDX[0], 2'b00}, {16'h0000, ecrc[0][31:16]}, r);
		axw({RIDX[1], 2'b00}, {16'h0000, ecrc[0][15:0]}, r);
		frame_chk(1, 2'b10);
		// empty mask with a zero expected value would hit without its guard
		for (i = 6; i < 12; i++) axw({RIDX[i], 2'b00}, 32'h0, r);
		frame_chk(0, 2'b00);
		$display("test enable and halves done");
		end_sim();
	end
endmodule : wakeup_pattern_crc_match_test
